/* wepc_consts.vh */
// constants of the wake event and power control block
`ifndef WEPC_CONSTS_VH
`define WEPC_CONSTS_VH
`define WEPC_IDX_CTRL         10'h0d4
`define WEPC_IDX_TIMING       10'h0d6
`define WEPC_IDX_INT_STATUS   10'h0d8
`define WEPC_IDX_INT_MASK     10'h0dc
`define WEPC_IDX_EVENT_IN     10'h0e0
`define WEPC_IDX_STATE        10'h0e4
`define WEPC_IDX_GRR          10'h0e8
`define WEPC_ADDR_CTRL        12'h350
`define WEPC_ADDR_TIMING      12'h358
`define WEPC_ADDR_INT_STATUS  12'h360
`define WEPC_ADDR_INT_MASK    12'h370
`define WEPC_ADDR_EVENT_IN    12'h380
`define WEPC_ADDR_STATE       12'h390
`define WEPC_ADDR_GRR         12'h3a0
`define WEPC_CTRL_DELAY       14
`define WEPC_CTRL_POL         12
`define WEPC_CTRL_EN_HI       11
`define WEPC_CTRL_EN_LO       8
`define WEPC_CTRL_AUTO        7
`define WEPC_CTRL_TONORM      6
`define WEPC_CTRL_IND_HI      5
`define WEPC_CTRL_IND_LO      2
`define WEPC_TIMING_RESET     16'h080c
`define WEPC_MODE_NORMAL      2'b00
`define WEPC_MODE_ENERGY      2'b01
`define WEPC_MODE_SOFTDOWN    2'b10
`define WEPC_MODE_SAVING      2'b11
`define WEPC_IND_NONE         4'h0
`define WEPC_IND_ENERGY       4'h1
`define WEPC_IND_LINK         4'h2
`define WEPC_IND_MAGIC        4'h4
`define WEPC_IND_FRAME        4'h8
`define WEPC_ISR_ENERGY       2
`define WEPC_ISR_LINK         3
`define WEPC_CLK_HZ           100000000
`define WEPC_UNIT_WAKE_MS     16
`define WEPC_UNIT_SLEEP_S     1
`define WEPC_READY_CYCLES     8'h10
`endif

/* wepc_host_model.sv */
// host processor model issuing single ahb-lite word transfers
`timescale 1ns/10ps
`default_nettype none
module wepc_host_model (
   // ahb-lite master
   input  wire logic        hclk,
   output logic             hsel,
   output logic [11:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic [31:0] hrdata,
   input  wire logic        hreadyout
);
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end
   // timing fields stay at their nonzero defaults
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      integer n;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      for (n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : ~hwdata;
      @(posedge hclk);
      for (n = n; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
      q = hrdata;
      hwdata <= ~hwdata;
      wepc_power_control_tb_top.bound(n, 50);
   endtask
endmodule // wepc_host_model
`default_nettype wire

/* wepc_power_control.v */
// wake event and power control block with ahb-lite register slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "wepc_consts.vh"
// Summary of operation
// [R1] event output polarity follows control bit 12
// [R2] four wake source enables in bits 11-8
// [R3] only enabled events assert the event output
// [R4] auto wake leaves low power after wake time
// [R5] wake-to-normal switches mode after energy wake
// [R6] four-bit wake event indication field, one bit per wake event kind
// [R7] energy and link wakes set status bits
// [R8] indication cleared by power-up reset or W1C
// [R9] cleared indication deasserts event output
// [R10] mode field: normal, energy, soft down, saving
// [R11] energy mode has low and normal power
// [R12] soft down exits on reset register read or on a control register write of another mode
// [R13] energy held wake field times 16 ms
// [R14] no energy held sleep field times 1 s
// [R15] host never programs zero timing fields
// [R16] delay enable together with auto wake holds off event output until ready
// [R17] coarse prescaled tick makes time units
module wepc_power_control #(
   parameter TICK_MS_CYCLES = `WEPC_CLK_HZ / 1000,
   parameter MS_PER_SEC     = 1000
) (
   // ahb-lite slave
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // wake detectors and line energy
   input  wire        det_frame,
   input  wire        det_magic,
   input  wire        det_link_up,
   input  wire        energy_present,
   // block outputs
   output reg         power_event_output,
   output reg         low_power,
   output reg  [1:0]  power_mode,
   output reg         irq
);
   // ms tick prescaler
   reg  [31:0] pre_cnt;
   reg         ms_tick;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end else if (pre_cnt >= TICK_MS_CYCLES - 1) begin
         pre_cnt <= 32'h0000_0000; // [R17]
         ms_tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 32'h0000_0001;
         ms_tick <= 1'b0;
      end
   end

   // registers
   reg         delay_en;
   reg         pol;
   reg  [3:0]  src_en;
   reg         auto_wake;
   reg         to_normal;
   reg  [3:0]  indication;
   reg  [15:0] timing;
   reg  [3:0]  int_status;
   reg  [3:0]  int_mask;
   reg  [7:0]  ready_cnt;

   // address phase capture, word index of the register
   reg         ph_valid;
   reg         ph_write;
   reg  [9:0]  ph_idx;
   wire        take = hsel & htrans[1] & hready;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_idx   <= 10'h000;
      end else if (hready) begin
         ph_valid <= take;
         ph_write <= hwrite;
         ph_idx   <= haddr[11:2];
      end
   end

   // register decode, writes land in the data phase
   wire        wr         = ph_valid & ph_write;
   wire        wr_ctrl    = wr & (ph_idx == `WEPC_IDX_CTRL);
   wire        wr_timing  = wr & (ph_idx == `WEPC_IDX_TIMING);
   wire        wr_status  = wr & (ph_idx == `WEPC_IDX_INT_STATUS);
   wire        wr_mask    = wr & (ph_idx == `WEPC_IDX_INT_MASK);
   wire [1:0]  wr_mode    = hwdata[1:0];
   wire        mode_leave = wr_ctrl & (wr_mode != `WEPC_MODE_ENERGY);
   wire        rd_take    = take & ~hwrite;
   wire        grr_read   = rd_take & (haddr[11:2] == `WEPC_IDX_GRR); // [R12]

   // energy qualification counters
   reg  [11:0] ms_cnt;
   reg  [9:0]  sub_ms;
   wire [11:0] wake_ms = {4'h0, timing[15:8]} << 4;
   wire        sec_tick = ms_tick & (sub_ms >= MS_PER_SEC - 1);
   reg  [7:0]  sec_cnt;
   wire        energy_mode = (power_mode == `WEPC_MODE_ENERGY); // [R11]
   wire        wake_ok = low_power & auto_wake & energy_present &
                         ms_tick & (ms_cnt + 12'h001 >= wake_ms); // [R4] [R13]
   wire        sleep_ok = ~low_power & energy_mode & ~energy_present &
                          sec_tick & (sec_cnt + 8'h01 >= timing[7:0]); // [R14]

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt  <= 12'h000;
         sub_ms  <= 10'h000;
         sec_cnt <= 8'h00;
      end else begin
         if (!energy_present || !low_power)
            ms_cnt <= 12'h000;
         else if (ms_tick && ms_cnt != 12'hfff)
            ms_cnt <= ms_cnt + 12'h001;
         if (ms_tick)
            sub_ms <= (sub_ms >= MS_PER_SEC - 1) ? 10'h000 : sub_ms + 10'h001;
         if (energy_present || low_power || !energy_mode)
            sec_cnt <= 8'h00;
         else if (sec_tick && sec_cnt != 8'hff)
            sec_cnt <= sec_cnt + 8'h01;
      end
   end

   // event capture, one-hot priority frame > magic > link > energy
   reg  [3:0] next_ind_set;
   always @* begin
      next_ind_set = `WEPC_IND_NONE;
      if (det_frame)
         next_ind_set = `WEPC_IND_FRAME; // [R6]
      else if (det_magic)
         next_ind_set = `WEPC_IND_MAGIC;
      else if (det_link_up)
         next_ind_set = `WEPC_IND_LINK;
      else if (wake_ok)
         next_ind_set = `WEPC_IND_ENERGY;
   end
   wire [3:0] w1c_ind = wr_ctrl ? hwdata[`WEPC_CTRL_IND_HI:`WEPC_CTRL_IND_LO] : 4'h0;
   wire [3:0] w1c_isr = wr_status ? hwdata[3:0] : 4'h0;
   wire [3:0] isr_set = {next_ind_set == `WEPC_IND_LINK,
                         next_ind_set == `WEPC_IND_ENERGY, 2'b00}; // [R7]

   // control fields
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         delay_en  <= 1'b0;
         pol       <= 1'b0;
         src_en    <= 4'h0;
         auto_wake <= 1'b0;
         to_normal <= 1'b0;
      end else if (wr_ctrl) begin
         delay_en  <= hwdata[`WEPC_CTRL_DELAY]; // [R16]
         pol       <= hwdata[`WEPC_CTRL_POL]; // [R1]
         src_en    <= hwdata[`WEPC_CTRL_EN_HI:`WEPC_CTRL_EN_LO]; // [R2]
         auto_wake <= hwdata[`WEPC_CTRL_AUTO]; // [R4]
         to_normal <= hwdata[`WEPC_CTRL_TONORM]; // [R5]
      end
   end

   // wake event indication, a new event wins over the clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         indication <= `WEPC_IND_NONE; // [R8]
      end else begin
         indication <= (indication & ~w1c_ind) | next_ind_set; // [R6] [R8]
      end
   end

   // interrupt status, set wins over the clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= 4'h0;
      end else begin
         int_status <= (int_status & ~w1c_isr) | isr_set; // [R7]
      end
   end

   // go-sleep and wake-up timing fields
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timing <= `WEPC_TIMING_RESET;
      end else if (wr_timing) begin
         timing <= hwdata[15:0]; // [R13] [R14]
      end
   end

   // interrupt mask
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_mask <= 4'h0;
      end else if (wr_mask) begin
         int_mask <= hwdata[3:0];
      end
   end

   // power mode, a software write wins over automatic changes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_mode <= `WEPC_MODE_NORMAL;
      end else if (wr_ctrl) begin
         power_mode <= wr_mode; // [R10]
      end else if (power_mode == `WEPC_MODE_SOFTDOWN && grr_read) begin
         power_mode <= `WEPC_MODE_NORMAL; // [R12]
      end else if (wake_ok && energy_mode && to_normal) begin
         power_mode <= `WEPC_MODE_NORMAL; // [R5]
      end
   end

   // low power substate, dropped in the same cycle as the mode leaves
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_power <= 1'b0;
      end else if (!energy_mode || mode_leave) begin
         low_power <= 1'b0; // [R11]
      end else if (wake_ok) begin
         low_power <= 1'b0; // [R4]
      end else if (sleep_ok) begin
         low_power <= 1'b1; // [R14]
      end
   end

   // readiness after leaving low power or soft power down
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_cnt <= 8'h00;
      end else if (low_power || power_mode == `WEPC_MODE_SOFTDOWN) begin
         ready_cnt <= 8'h00;
      end else if (ready_cnt != `WEPC_READY_CYCLES) begin
         ready_cnt <= ready_cnt + 8'h01; // [R16]
      end
   end

   // event pin, asserted level is pol and idle level is ~pol
   wire [3:0] active   = indication & src_en; // [R3]
   wire       hold_off = delay_en & auto_wake & (ready_cnt != `WEPC_READY_CYCLES); // [R16]
   wire       next_pin = (active != 4'h0 && !hold_off) ? pol : ~pol; // [R1] [R9]
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_event_output <= 1'b1;
      end else begin
         power_event_output <= next_pin;
      end
   end

   // level interrupt
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   // read data selection by word index
   reg  [31:0] next_hrdata;
   always @* begin
      next_hrdata = 32'h0000_0000;
      case (haddr[11:2])
         `WEPC_IDX_CTRL: begin
            next_hrdata = {17'h0_0000, delay_en, 1'b0, pol, src_en, auto_wake,
                           to_normal, indication, power_mode};
         end
         `WEPC_IDX_TIMING: begin
            next_hrdata = {16'h0000, timing};
         end
         `WEPC_IDX_INT_STATUS: begin
            next_hrdata = {28'h000_0000, int_status};
         end
         `WEPC_IDX_INT_MASK: begin
            next_hrdata = {28'h000_0000, int_mask};
         end
         `WEPC_IDX_EVENT_IN: begin
            next_hrdata = {28'h000_0000, det_frame, det_magic, det_link_up, energy_present};
         end
         `WEPC_IDX_STATE: begin
            next_hrdata = {29'h0000_0000, low_power, power_mode};
         end
         default: begin
            next_hrdata = 32'h0000_0000;
         end
      endcase
   end

   // read data register, loaded when a read is taken
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= next_hrdata;
      end
   end

   // zero wait states and an okay response
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule // wepc_power_control
`default_nettype wire

/* wepc_power_control_properties.sv */
// port checker of the wake event and power control block
`timescale 1ns/10ps
`default_nettype none
module wepc_power_control_properties #(parameter TICK_MS_CYCLES = 100000, MS_PER_SEC = 1000) (
   input wire logic       hclk, hresetn, hsel, hreadyout, hresp,
   input wire logic       energy_present, low_power,
   input wire logic [1:0] power_mode
);
   localparam int WMIN = 128 * TICK_MS_CYCLES / 5;
   localparam int WMAX = 128 * TICK_MS_CYCLES * 9 / 5;
   localparam int SMIN = 12 * MS_PER_SEC * TICK_MS_CYCLES / 5;
   logic [31:0] e_cnt;
   logic [31:0] q_cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         e_cnt <= 32'h0000_0000;
         q_cnt <= 32'h0000_0000;
      end else begin
         e_cnt <= energy_present ? e_cnt + 32'h0000_0001 : 32'h0000_0000;
         q_cnt <= energy_present ? 32'h0000_0000 : q_cnt + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
   a_low_mode: assert property (low_power |-> power_mode == 2'b01)
      else $error("low power off mode");
   a_low_holds: assert property (low_power && !energy_present && !$past(hsel) |=> low_power)
      else $error("woke unpowered");
   a_awake_holds: assert property (!low_power && energy_present |=> !low_power)
      else $error("slept with energy");
   a_wake_min: assert property ($fell(low_power) |-> e_cnt >= WMIN)
      else $error("woke early");
   a_wake_max: assert property (low_power |-> e_cnt <= WMAX)
      else $error("woke late");
   a_sleep_min: assert property ($rose(low_power) |-> q_cnt >= SMIN)
      else $error("slept early");
   a_soft_stays: assert property ((power_mode == 2'b10 && !hsel) [*4] |=> power_mode == 2'b10)
      else $error("left soft down");
   c_sleep: cover property ($rose(low_power));
   c_wake: cover property ($fell(low_power));
   c_soft: cover property (power_mode == 2'b10 ##1 power_mode == 2'b00);
endmodule // wepc_power_control_properties
bind wepc_power_control wepc_power_control_properties #(
   .TICK_MS_CYCLES(TICK_MS_CYCLES), .MS_PER_SEC(MS_PER_SEC)) i_wepc_power_control_properties (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hreadyout(hreadyout), .hresp(hresp),
   .energy_present(energy_present), .low_power(low_power), .power_mode(power_mode));
`default_nettype wire

/* wepc_power_control_tb_top.sv */
// self-checking testbench of the wake event and power control block
`timescale 1ns/10ps
`default_nettype none
`include "wepc_consts.vh"
module wepc_power_control_tb_top;
   localparam int TICK = 10;
   logic        hclk, hresetn;
   logic [3:0]  dv;
   logic [31:0] rdv;
   wire         hsel, hwrite, hreadyout, hresp, power_event_output, low_power, irq;
   wire  [11:0] haddr;
   wire  [1:0]  htrans, power_mode;
   wire  [2:0]  hsize;
   wire  [31:0] hwdata, hrdata;
   integer      miscompares, samples_checked, n, i;
   wepc_host_model i_wepc_host_model (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout));
   wepc_power_control #(.TICK_MS_CYCLES(TICK), .MS_PER_SEC(4)) i_wepc_power_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .det_frame(dv[3]), .det_magic(dv[2]),
      .det_link_up(dv[1]), .energy_present(dv[0]), .power_event_output(power_event_output),
      .low_power(low_power), .power_mode(power_mode), .irq(irq));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bound(input integer got, input integer lim);
      if (got >= lim) begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_wepc_host_model.xfer(1'b1, a, d, rdv);
   endtask
   task automatic rd(input logic [11:0] a);
      i_wepc_host_model.xfer(1'b0, a, 32'h0000_0000, rdv);
   endtask
   task automatic tick(input integer k);
      repeat (k) @(posedge hclk);
      #1;
   endtask
   task automatic pulse(input logic [3:0] b);
      dv <= b;
      tick(1);
      dv <= 4'h0;
      tick(3);
   endtask
   task automatic t_reset;
      chk(power_event_output, 1'b1);
      rd(`WEPC_ADDR_CTRL);
      chk(rdv, 32'h0000_0000);
      rd(`WEPC_ADDR_TIMING);
      chk(rdv, 32'h0000_080c);
      rd(12'h3c0);
      chk(rdv, 32'h0000_0000);
   endtask
   task automatic t_events;
      logic [3:0] ev;
      integer     j;
      wr(`WEPC_ADDR_INT_MASK, 32'h0000_0008);
      for (i = 1; i < 4; i++) begin
         j = (i % 3) + 1;
         ev = (4'h1 << i) | (4'h1 << j);
         wr(`WEPC_ADDR_CTRL, 32'h0000_1000 | (32'h0000_0100 << i));
         pulse(4'h1 << j);
         chk(power_event_output, 1'b0);
         pulse(4'h1 << i);
         chk(power_event_output, 1'b1);
         rd(`WEPC_ADDR_CTRL);
         chk(rdv[5:2], ev);
         rd(`WEPC_ADDR_INT_STATUS);
         chk(rdv[3:2], ev[1:0]);
         chk(irq, ev[1]);
         wr(`WEPC_ADDR_INT_STATUS, 32'h0000_000c);
         wr(`WEPC_ADDR_CTRL, 32'h0000_103c | (32'h0000_0100 << i));
         tick(3);
         chk(power_event_output, 1'b0);
         chk(irq, 1'b0);
      end
   endtask
   task automatic t_energy;
      wr(`WEPC_ADDR_CTRL, 32'h0000_51c1);
      for (n = 0; n < 1000 && low_power !== 1'b1; n++) tick(1);
      bound(n, 1000);
      chk(power_mode, `WEPC_MODE_ENERGY);
      dv <= 4'h1;
      for (n = 0; n < 3000 && low_power !== 1'b0; n++) tick(1);
      bound(n, 3000);
      chk(n >= 128 * TICK / 5 && n <= 128 * TICK * 9 / 5, 1'b1);
      chk(power_mode, `WEPC_MODE_NORMAL);
      chk(power_event_output, 1'b0);
      tick(20);
      chk(power_event_output, 1'b1);
      rd(`WEPC_ADDR_CTRL);
      chk(rdv[5:2], `WEPC_IND_ENERGY);
      rd(`WEPC_ADDR_INT_STATUS);
      chk(rdv[3:2], 2'b01);
      dv <= 4'h0;
   endtask
   task automatic t_soft;
      wr(`WEPC_ADDR_CTRL, 32'h0000_003e);
      pulse(4'h1);
      chk(power_event_output, 1'b1);
      chk(power_mode, `WEPC_MODE_SOFTDOWN);
      rd(`WEPC_ADDR_GRR);
      tick(3);
      chk(power_mode, `WEPC_MODE_NORMAL);
   endtask
   initial begin
      miscompares = 0;
      samples_checked = 0;
      hresetn = 1'b0;
      dv = 4'h0;
      tick(10);
      hresetn <= 1'b1;
      tick(1);
      t_reset();
      t_events();
      t_energy();
      t_soft();
      close_out();
   end
endmodule // wepc_power_control_tb_top
`default_nettype wire
